// ---- common/asp_pkg.sv ----
/*
 * shared constants and types of the converter serial port:
 * register select codes, frame lengths, status layout, state and carriers.
 * assumes one system clock and a converter core on that same clock.
 */
package asp_pkg;

	// ============================================================
	// register select codes
	localparam logic [1:0] SEL_COMM_STAT = 2'h0;
	localparam logic [1:0] SEL_MODE = 2'h1;
	localparam logic [1:0] SEL_FILTER = 2'h2;
	localparam logic [1:0] SEL_DATA = 2'h3;

	// ============================================================
	// command byte layout, first bit on the wire is bit 7
	localparam int CMD_WEN_BIT = 7;
	localparam int CMD_SEL_HI = 5;
	localparam int CMD_SEL_LO = 4;
	localparam int CMD_READ_BIT = 3;

	// ============================================================
	// frame lengths in serial clocks
	localparam logic [4:0] LEN_CMD = 5'h08;
	localparam logic [4:0] LEN_BYTE = 5'h08;
	localparam logic [4:0] LEN_WORD = 5'h10;
	localparam logic [5:0] RESYNC_ONES = 6'h20;

	// ============================================================
	// status byte: bit 7 is the not-ready flag, bit 3 reads as one
	localparam int STAT_RDY_BIT = 7;
	localparam logic [7:0] STAT_FIXED = 8'h08;

	// ============================================================
	// port states
	typedef enum logic [1:0] {
		ST_CMD = 2'b00,
		ST_WR = 2'b01,
		ST_RD = 2'b10,
		ST_PUSH = 2'b11
	} asp_state_e;

	// a word written by the host for one control register
	typedef struct packed {
		logic [1:0] sel;
		logic [15:0] data;
	} asp_word_s;

	// all state of the serial port
	typedef struct packed {
		logic sclk1;
		logic sclk2;
		logic sclk3;
		logic cs1;
		logic cs2;
		logic din1;
		logic din2;
		asp_state_e state;
		logic [4:0] bitCnt;
		logic [4:0] bitLen;
		logic [1:0] regSel;
		logic [15:0] inSh;
		logic [15:0] outSh;
		logic outBit;
		logic [5:0] onesCnt;
		logic rdy;
		logic [15:0] dataReg;
		asp_word_s pend;
		asp_word_s buf0;
		asp_word_s buf1;
		logic [1:0] fill;
		logic wrValid;
		logic dout;
		logic doutOe;
	} asp_regs_s;

	// sync stages start at the idle pin levels, so reset shows no false edge
	localparam asp_regs_s REGS_RST = '{state: ST_CMD, sclk1: 1'b1,
		sclk2: 1'b1, sclk3: 1'b1, cs1: 1'b1, cs2: 1'b1, dout: 1'b1,
		default: '0};

endpackage

// ---- src/asp_serial_port.sv ----
/*
 * device end of the converter serial port: command byte decode,
 * register reads and writes, ready signalling on the shared output pin,
 * resync on a long run of ones and a two-entry buffer for written words.
 * assumes pins arrive asynchronous to sys_clk; converter core and the
 * control register file run on sys_clk.
 */
`timescale 1ns/1ps
// Summary of operation
// - serial clock may be continuous or gated in bursts; bit position holds between edges.
// - chip select is active low and traffic counts only while it is low.
// - chip select may frame each transfer and such framed transfers are accepted.
// - with chip select tied low the port works with clock, input and output only.
// - the output pin drives the output shift register loaded from the selected register.
// - a finished conversion pulls the output pin low to mark a new result.
// - an unread result lets the ready indication return high before the next update.
// - output bits change on serial clock falling edges and are sampled on rising ones.
// - conversion completion also shows as the ready flag in the status register.
// - with chip select high the output is released while the ready flag keeps tracking.
// - input bits shift into an input register and go to the register picked by the select bits.
// - reading the result returns the ready indication high.
// - 32 clocks with the input high reset the whole port to await a command byte.
module asp_serial_port (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic sclkPin,
	input wire logic csPin_n,
	input wire logic dinPin,
	output logic doutPin,
	output logic doutOe,
	input wire logic convDone,
	input wire logic [15:0] convData,
	input wire logic updateSoon,
	input wire logic [7:0] modeReg,
	input wire logic [7:0] filterReg,
	output logic rdyFlag,
	output logic wrValid,
	output asp_pkg::asp_word_s wrWord,
	input wire logic wrReady
);

	// ============================================================
	// state
	asp_pkg::asp_regs_s r;
	asp_pkg::asp_regs_s next_r;
	logic rise;
	logic fall;
	logic resync;
	logic rdClr;
	logic pop;
	logic push;
	logic [1:0] fillAfter;
	logic [7:0] cmd;
	logic [7:0] statusByte;

	// ============================================================
	// next state
	always_comb begin
		next_r = r;
		rdClr = 1'b0;
		cmd = {r.inSh[6:0], r.din2};
		statusByte = asp_pkg::STAT_FIXED;
		statusByte[asp_pkg::STAT_RDY_BIT] = ~r.rdy;
		// two-stage synchronisers, third sclk stage for edge finding
		next_r.sclk1 = sclkPin;
		next_r.sclk2 = r.sclk1;
		next_r.sclk3 = r.sclk2;
		next_r.cs1 = csPin_n;
		next_r.cs2 = r.cs1;
		next_r.din1 = dinPin;
		next_r.din2 = r.din1;
		// edges count only with select low; tied low gives three-wire use
		rise = r.sclk2 & ~r.sclk3 & ~r.cs2;
		fall = ~r.sclk2 & r.sclk3 & ~r.cs2;
		// 32nd rise in a row with the input high
		resync = rise && r.din2
			&& (r.onesCnt == asp_pkg::RESYNC_ONES - 6'h01);
		// output bits move only on falling edges
		if (fall && r.state == asp_pkg::ST_RD) begin
			next_r.outBit = r.outSh[15];
			next_r.outSh = {r.outSh[14:0], 1'b0};
		end
		// serial sequencer; position holds between edges and frames
		if (rise) begin
			case (r.state)
				asp_pkg::ST_CMD: begin
					if (r.bitCnt == 5'h00 && r.din2) begin
						next_r.bitCnt = 5'h00; // write enable bit not zero
					end else begin
						next_r.inSh = {r.inSh[14:0], r.din2};
						next_r.bitCnt = r.bitCnt + 5'h01;
						if (r.bitCnt == asp_pkg::LEN_CMD - 5'h01) begin
							next_r.bitCnt = 5'h00;
							next_r.inSh = 16'h0000; // data phase starts empty
							next_r.regSel = cmd[asp_pkg::CMD_SEL_HI:
								asp_pkg::CMD_SEL_LO];
							next_r.bitLen = (next_r.regSel ==
								asp_pkg::SEL_DATA) ? asp_pkg::LEN_WORD :
								asp_pkg::LEN_BYTE;
							if (cmd[asp_pkg::CMD_READ_BIT]) begin
								next_r.state = asp_pkg::ST_RD;
								// load output shift register
								if (next_r.regSel == asp_pkg::SEL_DATA) begin
									next_r.outSh = r.dataReg;
								end else if (next_r.regSel ==
									asp_pkg::SEL_MODE) begin
									next_r.outSh = {modeReg, 8'h00};
								end else if (next_r.regSel ==
									asp_pkg::SEL_FILTER) begin
									next_r.outSh = {filterReg, 8'h00};
								end else begin
									next_r.outSh = {statusByte, 8'h00};
								end
							end else if (next_r.regSel !=
								asp_pkg::SEL_COMM_STAT) begin
								next_r.state = asp_pkg::ST_WR;
							end
						end
					end
				end
				asp_pkg::ST_WR: begin
					next_r.inSh = {r.inSh[14:0], r.din2};
					next_r.bitCnt = r.bitCnt + 5'h01;
					if (r.bitCnt == r.bitLen - 5'h01) begin
						next_r.bitCnt = 5'h00;
						next_r.pend.sel = r.regSel;
						next_r.pend.data = {r.inSh[14:0], r.din2};
						next_r.state = asp_pkg::ST_PUSH;
					end
				end
				asp_pkg::ST_RD: begin
					next_r.bitCnt = r.bitCnt + 5'h01;
					if (r.bitCnt == r.bitLen - 5'h01) begin
						next_r.bitCnt = 5'h00;
						next_r.state = asp_pkg::ST_CMD;
						rdClr = (r.regSel == asp_pkg::SEL_DATA);
					end
				end
				default: begin
					next_r.bitCnt = r.bitCnt; // edges ignored while pushing
				end
			endcase
		end
		// two-entry buffer toward the control register file
		pop = wrReady & (r.fill != 2'h0);
		fillAfter = r.fill - {1'b0, pop};
		push = (r.state == asp_pkg::ST_PUSH) && (fillAfter != 2'h2);
		if (pop) begin
			next_r.buf0 = r.buf1;
		end
		if (push) begin
			if (fillAfter == 2'h0) begin
				next_r.buf0 = r.pend;
			end else begin
				next_r.buf1 = r.pend;
			end
			next_r.state = asp_pkg::ST_CMD;
		end
		next_r.fill = fillAfter + {1'b0, push};
		next_r.wrValid = (next_r.fill != 2'h0);
		// ready flag: a new result wins over a read or update clear, but the restart below still clears it
		if (convDone) begin
			next_r.rdy = 1'b1;
			next_r.dataReg = convData;
		end else if (rdClr || updateSoon) begin
			next_r.rdy = 1'b0;
		end
		// run of ones on the input restarts the whole port
		if (rise) begin
			next_r.onesCnt = r.din2 ? r.onesCnt + 6'h01 : 6'h00;
			if (resync) begin
				next_r = asp_pkg::REGS_RST;
				next_r.sclk1 = sclkPin;
				next_r.sclk2 = r.sclk1;
				next_r.sclk3 = r.sclk2;
				next_r.cs1 = csPin_n;
				next_r.cs2 = r.cs1;
				next_r.din1 = dinPin;
				next_r.din2 = r.din1;
			end
		end
		// shared pin: data while reading, else ready, released when deselected
		next_r.doutOe = ~r.cs2;
		next_r.dout = (r.state == asp_pkg::ST_RD) ? r.outBit : ~r.rdy;
	end

	// ============================================================
	// state register
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			r <= asp_pkg::REGS_RST;
		end else begin
			r <= next_r;
		end
	end

	// outputs straight from flops
	assign doutPin = r.dout;
	assign doutOe = r.doutOe;
	assign rdyFlag = r.rdy;
	assign wrValid = r.wrValid;
	assign wrWord = r.buf0;

	// ============================================================
	// checks
	// pin and ready indication
	a_ready_pulls_low: assert property (@(posedge sys_clk)
		disable iff (!rst_n)
		$rose(r.rdy) && r.state == asp_pkg::ST_CMD |=> !doutPin)
		else $error("ready not shown low on pin");

	a_release_when_high: assert property (@(posedge sys_clk)
		disable iff (!rst_n) r.cs2 |=> !doutOe)
		else $error("pin driven while deselected");

	a_drive_when_low: assert property (@(posedge sys_clk)
		disable iff (!rst_n) !r.cs2 |=> doutOe)
		else $error("pin not driven while selected");

	a_pin_shows_ready: assert property (@(posedge sys_clk)
		disable iff (!rst_n) r.state != asp_pkg::ST_RD
		|=> doutPin == !$past(r.rdy))
		else $error("idle pin does not mirror ready");

	a_data_on_pin: assert property (@(posedge sys_clk)
		disable iff (!rst_n) r.state == asp_pkg::ST_RD
		|=> doutPin == $past(r.outBit))
		else $error("pin does not show output shift bit");

	a_unread_goes_high: assert property (@(posedge sys_clk)
		disable iff (!rst_n) updateSoon && !convDone |=> !r.rdy)
		else $error("ready kept across update");

	a_done_sets_flag: assert property (@(posedge sys_clk)
		disable iff (!rst_n) convDone
		&& !(rise && r.din2 && r.onesCnt == 6'h1f) |=> rdyFlag)
		else $error("ready flag not set");

	a_read_clears_rdy: assert property (@(posedge sys_clk)
		disable iff (!rst_n) rdClr && !convDone |=> !r.rdy ##1 doutPin)
		else $error("ready kept after data read");

	// serial position and sequencing
	a_hold_between: assert property (@(posedge sys_clk)
		disable iff (!rst_n)
		!rise && r.state == asp_pkg::ST_WR |=> $stable(r.bitCnt))
		else $error("bit position moved without edge");

	a_ignore_deselect: assert property (@(posedge sys_clk)
		disable iff (!rst_n) r.cs2 && r.state != asp_pkg::ST_PUSH
		|=> $stable(r.bitCnt) && $stable(r.inSh))
		else $error("traffic taken while deselected");

	a_out_on_fall: assert property (@(posedge sys_clk)
		disable iff (!rst_n) $changed(r.outBit)
		|-> $past(fall) || $past(resync))
		else $error("output bit moved off falling edge");

	a_resync_ones: assert property (@(posedge sys_clk)
		disable iff (!rst_n) rise && r.din2 && r.onesCnt == 6'h1f
		|=> r.state == asp_pkg::ST_CMD && r.bitCnt == 5'h00
		&& r.fill == 2'h0 && !r.rdy)
		else $error("no restart after run of ones");

	a_wen_refused: assert property (@(posedge sys_clk)
		disable iff (!rst_n) rise && r.state == asp_pkg::ST_CMD
		&& r.bitCnt == 5'h00 && r.din2
		|=> r.state == asp_pkg::ST_CMD && r.bitCnt == 5'h00)
		else $error("command start taken with enable bit set");

	a_read_returns: assert property (@(posedge sys_clk)
		disable iff (!rst_n) rise && r.state == asp_pkg::ST_RD
		&& r.bitCnt == r.bitLen - 5'h01
		|=> r.state == asp_pkg::ST_CMD && r.bitCnt == 5'h00)
		else $error("no return to command after read");

	a_msb_first_in: assert property (@(posedge sys_clk)
		disable iff (!rst_n)
		rise && r.state == asp_pkg::ST_WR && r.onesCnt != 6'h1f
		|=> r.inSh[0] == $past(r.din2))
		else $error("input bit not shifted in");

	// write buffer toward the register file
	a_write_to_push: assert property (@(posedge sys_clk)
		disable iff (!rst_n) rise && r.state == asp_pkg::ST_WR
		&& r.bitCnt == r.bitLen - 5'h01 && !resync
		|=> r.state == asp_pkg::ST_PUSH && r.pend.sel == $past(r.regSel))
		else $error("written word not handed on");

	a_write_reaches_buf: assert property (@(posedge sys_clk)
		disable iff (!rst_n) r.state == asp_pkg::ST_PUSH && r.fill == 2'h0
		|=> wrValid && wrWord == $past(r.pend))
		else $error("written word lost");

	a_buf_never_over: assert property (@(posedge sys_clk)
		disable iff (!rst_n) r.fill != 2'h3)
		else $error("write buffer overfilled");

	a_stall_keeps: assert property (@(posedge sys_clk)
		disable iff (!rst_n) r.state == asp_pkg::ST_PUSH && r.fill == 2'h2
		&& !wrReady && !resync |=> r.state == asp_pkg::ST_PUSH && wrValid)
		else $error("stalled word dropped");

	a_pop_advances: assert property (@(posedge sys_clk)
		disable iff (!rst_n) wrValid && wrReady && r.fill == 2'h2 && !resync
		|=> wrValid && wrWord == $past(r.buf1))
		else $error("buffer head did not advance");

endmodule // asp_serial_port

// ---- test/adc_serial_port_pins_tb.sv ----
/*
 * self-checking bench of the converter serial port with a host model.
 * assumes the design and its package compile ahead of this file.
 */
`timescale 1ns/1ps
module adc_serial_port_pins_tb;
	logic sys_clk, rst_n, sclkPin, csPin_n, dinPin, doutPin, doutOe;
	logic convDone, updateSoon, rdyFlag, wrValid, wrReady;
	logic [15:0] convData, rd;
	logic [7:0] modeReg, filterReg;
	asp_pkg::asp_word_s wrWord;
	int n_errors, samples_checked;

	// ============================================================
	// clock and instances
	always #5 sys_clk = ~sys_clk;

	asp_serial_port i_dut (.sys_clk(sys_clk), .rst_n(rst_n),
		.sclkPin(sclkPin), .csPin_n(csPin_n), .dinPin(dinPin),
		.doutPin(doutPin), .doutOe(doutOe), .convDone(convDone),
		.convData(convData), .updateSoon(updateSoon), .modeReg(modeReg),
		.filterReg(filterReg), .rdyFlag(rdyFlag), .wrValid(wrValid),
		.wrWord(wrWord), .wrReady(wrReady));

	asp_host_model i_host (.sys_clk(sys_clk), .doutPin(doutPin),
		.doutOe(doutOe),
		.sclkPin(sclkPin), .csPin_n(csPin_n), .dinPin(dinPin));

	// ============================================================
	// compare, verdict and core-side helpers
	task automatic check(input logic [17:0] seen, input logic [17:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_of_test();
		$display("checks %0d, mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// one-cycle pulse: new result, or warning of the next update
	task automatic pulse(input logic isDone);
		@(negedge sys_clk);
		convDone = isDone;
		updateSoon = ~isDone;
		@(negedge sys_clk);
		convDone = 1'b0;
		updateSoon = 1'b0;
		repeat (4) @(negedge sys_clk);
	endtask

	// take one written word off the buffer head
	task automatic pop(input logic [17:0] exp);
		repeat (4) @(negedge sys_clk);
		check(wrValid, 1'b1);
		check(wrWord, exp);
		wrReady = 1'b1;
		@(negedge sys_clk);
		wrReady = 1'b0;
	endtask

	// ============================================================
	// scenarios
	task automatic t_writes();
		for (int i = 1; i <= 3; i++) begin
			i_host.sel(1'b0);
			i_host.xfer(8'h10, 16'h00a0 + 16'(i), 8, 0, rd);
			i_host.sel(1'b1);
		end
		for (int i = 1; i <= 3; i++) pop({2'h1, 16'h00a0 + 16'(i)});
	endtask

	task automatic t_ready();
		i_host.sel(1'b0);
		i_host.xfer(8'h08, 16'h0000, 8, 0, rd);
		check(rd[7:0], 8'h88);
		pulse(1'b1);
		check({rdyFlag, doutOe, doutPin}, 3'h6);
		i_host.xfer(8'h08, 16'h0000, 8, 0, rd);
		check(rd[7:0], 8'h08);
		i_host.xfer(8'h18, 16'h0000, 8, 0, rd);
		check(rd[7:0], modeReg);
		i_host.xfer(8'h28, 16'h0000, 8, 0, rd);
		check(rd[7:0], filterReg);
		i_host.xfer(8'h38, 16'h0000, 16, 0, rd);
		check(rd, 16'hbeef);
		repeat (4) @(negedge sys_clk);
		check({rdyFlag, doutPin}, 2'h1);
		i_host.sel(1'b1);
		check(doutOe, 1'b0);
	endtask

	task automatic t_idle();
		i_host.xfer(8'h10, 16'h0077, 8, 0, rd);
		repeat (6) @(negedge sys_clk);
		check(wrValid, 1'b0);
		pulse(1'b1);
		check({rdyFlag, doutOe}, 2'h2);
		i_host.sel(1'b0);
		check({doutOe, doutPin}, 2'h2);
		pulse(1'b0);
		check({rdyFlag, doutPin}, 2'h1);
	endtask

	task automatic t_gated();
		i_host.xfer(8'h20, 16'h0055, 8, 9, rd);
		pop({2'h2, 16'h0055});
		// part of a mode read, so only the restart can clear ready
		for (int i = 0; i < 3; i++) i_host.bitx(1'b0, 0, rd);
		pulse(1'b1);
		check(rdyFlag, 1'b1);
		i_host.resync();
		check(rdyFlag, 1'b0);
		i_host.xfer(8'h00, 16'h0000, 0, 0, rd);
		repeat (6) @(negedge sys_clk);
		check(wrValid, 1'b0);
		i_host.xfer(8'h10, 16'h005a, 8, 0, rd);
		pop({2'h1, 16'h005a});
	endtask

	// ============================================================
	// main sequence and watchdog
	initial begin
		sys_clk = 1'b0;
		rst_n = 1'b0;
		convDone = 1'b0;
		updateSoon = 1'b0;
		wrReady = 1'b0;
		convData = 16'hbeef;
		modeReg = 8'h02;
		filterReg = 8'h04;
		n_errors = 0;
		samples_checked = 0;
		repeat (2) @(negedge sys_clk);
		rst_n = 1'b1;
		repeat (4) @(negedge sys_clk);
		check({doutOe, doutPin, rdyFlag, wrValid}, 4'h4);
		t_writes();
		t_ready();
		t_idle();
		t_gated();
		end_of_test();
	end

	initial begin
		repeat (20000) @(posedge sys_clk);
		n_errors++;
		end_of_test();
	end
endmodule // adc_serial_port_pins_tb

// ---- test/asp_host_model.sv ----
/*
 * host serial master model: frames, gated clock bursts, read back.
 * assumes sys_clk at 100 MHz and a link clock of 80 ns period.
 */
`timescale 1ns/1ps
module asp_host_model (
	input wire logic sys_clk,
	input wire logic doutPin,
	input wire logic doutOe,
	output logic sclkPin,
	output logic csPin_n,
	output logic dinPin
);
	// ============================================================
	// idle: clock parked high, chip select off
	initial begin
		sclkPin = 1'b1;
		csPin_n = 1'b1;
		dinPin = 1'b0;
	end

	// move chip select, then let the synchronisers settle
	task automatic sel(input logic v);
		@(negedge sys_clk);
		csPin_n = v;
		repeat (4) @(negedge sys_clk);
	endtask

	// one bit: data moves with the falling clock, read late in high phase
	task automatic bitx(input logic b, input int gap,
		inout logic [15:0] rd);
		@(negedge sys_clk);
		sclkPin = 1'b0;
		dinPin = b;
		repeat (4) @(negedge sys_clk);
		sclkPin = 1'b1;
		repeat (3) @(negedge sys_clk);
		// a released line reads as its pull-up level
		rd = {rd[14:0], doutOe ? doutPin : 1'b1};
		repeat (gap) @(negedge sys_clk);
	endtask

	// command byte, then a data phase of 0, 8 or 16 bits
	task automatic xfer(input logic [7:0] cmd, input logic [15:0] dat,
		input int nDat, input int gap, output logic [15:0] rd);
		rd = '0;
		for (int i = 7; i >= 0; i--) bitx(cmd[i], gap, rd);
		for (int i = nDat - 1; i >= 0; i--) bitx(dat[i], gap, rd);
	endtask

	// thirty-two ones bring a lost port back to the command byte
	task automatic resync();
		logic [15:0] rd;
		for (int i = 0; i < 32; i++) bitx(1'b1, 0, rd);
	endtask
endmodule // asp_host_model
